// ===== pkg/drc_pkg.sv
/*
 Shared constants and types for the drive supervisory control block:
 register offsets, settings layout, reset values, trip cause codes,
 retry states and timing. Assumes a 40 MHz clock and a 32-bit Wishbone bus.
*/
`default_nettype none
package drc_pkg;
   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_INTERVAL = 8'h04;
   localparam logic [7:0] OFS_RAMP     = 8'h08;
   localparam logic [7:0] OFS_CMD      = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_TRIPVIEW = 8'h14;
   localparam logic [7:0] OFS_TOPF     = 8'h18;
   localparam logic [7:0] OFS_UPPERF   = 8'h1C;

   // Command register bit positions (write-only events)
   localparam int CMD_CONFIRM = 0;
   localparam int CMD_RESET   = 1;
   localparam int CMD_STOP    = 2;
   localparam int CMD_RUN     = 3;

   // -----------------------------------------------------------------
   // Settings layout, low bit first is retry_count_setting
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       factory_restore_select;     // bit 16
      logic [2:0] low_speed_boost_setting;    // bits 15:13
      logic [1:0] power_loss_restart_select;  // bits 12:11
      logic       halt_method_select;         // bit 10
      logic       power_saving_select;        // bit 9
      logic [1:0] coasting_pickup_select;     // bits 8:7
      logic [1:0] ramp_shape_select;          // bits 6:5
      logic       fan_thermal_control_select; // bit 4
      logic [3:0] retry_count_setting;        // bits 3:0
   } drc_cfg_type;

   localparam int CFG_W = 17;
   localparam logic [16:0] CFG_RST = 17'h00010; // Fan under thermal control
   localparam logic [3:0] RETRY_MAX = 4'hA;
   localparam logic [4:0] INTERVAL_MIN = 5'h02;   // Seconds
   localparam logic [4:0] INTERVAL_MAX = 5'h14;
   localparam logic [4:0] INTERVAL_RST = 5'h02;
   localparam logic [15:0] RAMP_RST = 16'h003C;   // 0.1 s units
   localparam logic [15:0] RAMP_LIN_MIN = 16'h0002;
   localparam logic [15:0] RAMP_LIN_MAX = 16'h8CA0;
   localparam logic [15:0] TOPF_RST = 16'h0258;   // 0.1 Hz units
   localparam logic [15:0] UPPERF_RST = 16'h02BC;
   localparam logic [15:0] PICKUP_MAX = 16'h04B0; // 120.0 Hz

   // Trip cause codes
   localparam logic [3:0] TRIP_NONE                     = 4'h0;
   localparam logic [3:0] overcurrent_trip              = 4'h1;
   localparam logic [3:0] overvoltage_trip              = 4'h2;
   localparam logic [3:0] heatsink_overheat_trip        = 4'h3;
   localparam logic [3:0] brake_resistor_overheat_trip  = 4'h4;
   localparam logic [3:0] first_motor_overload_trip     = 4'h5;
   localparam logic [3:0] second_motor_overload_trip    = 4'h6;
   localparam logic [3:0] drive_overload_trip           = 4'h7;

   // Retry sequencer states
   typedef enum logic [1:0] {
      DRC_ST_RUN   = 2'b00,
      DRC_ST_WAIT  = 2'b01,
      DRC_ST_ALARM = 2'b10
   } drc_state_type;

   // Timing
   localparam int CLK_HZ     = 40000000;
   localparam int SEC_TIME_S = 1;
   localparam int CYC_PER_S  = CLK_HZ * SEC_TIME_S;
endpackage
`default_nettype wire

// ===== logic/drc_top.sv
/*
 Drive supervisory control: trip history, factory restore, automatic
 retry sequencer, fan switching, ramp shape, coasting pickup, energy
 saving and stop method. Assumes a classic Wishbone master, synchronous
 inputs and a power stage that acts on the start and stop outputs.
*/
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
// Notes on behaviour
// - Keep four latest trips, read newest first
// - New trip shifts history, oldest dropped
// - Confirmed restore loads defaults, clears itself
// - Retry count 0 to 10, 0 disables
// - Retry interval 2 to 20 seconds
// - Only seven trip causes qualify for retry
// - After interval, issue own start command
// - Persisting cause trips again, waits again
// - Retries used up means alarm
// - Fan thermal control or always on
// - Ramp shape linear, weak, strong, non-linear
// - Curved shape holds ramp time mid-ramp
// - Extreme ramp time forces weak or strong curve to linear
// - Pickup at coasting frequency unless too high
// - Pickup off, power-loss only, or always
// - Power-loss pickup needs restart select 2/3
// - Light-load constant speed lowers voltage
// - No saving while ramping or torque limited
// - Stop method ramped or coast
// - Stop method applies only to stop command
`timescale 1ns/1ps
`default_nettype none
module drc_top
   import drc_pkg::*;
#(
   parameter int CYC_S = CYC_PER_S
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        trip_in,
   input  wire logic [3:0]  trip_cause_in,
   input  wire logic        power_loss_restart_in,
   input  wire logic [15:0] coast_freq_in,
   input  wire logic        heatsink_hot_in,
   input  wire logic        accel_in,
   input  wire logic        decel_in,
   input  wire logic        at_speed_in,
   input  wire logic        stopped_in,
   input  wire logic        light_load_in,
   input  wire logic        torque_limit_in,
   output logic             start_out,
   output logic      [15:0] start_freq_out,
   output logic             pickup_out,
   output logic             auto_start_out,
   output logic             running_out,
   output logic             coast_out,
   output logic             ramp_stop_out,
   output logic             alarm_out,
   output logic             fan_on_out,
   output logic             energy_save_out,
   output logic      [1:0]  ramp_shape_out,
   output logic      [15:0] ramp_time_out
);
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Byte-lane merge, shared by every writable register except the command and trip view registers
   function automatic logic [31:0] drc_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Clamp a value into a closed range
   function automatic logic [4:0] drc_clamp(input logic [4:0] v,
      input logic [4:0] lo, input logic [4:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   localparam logic [25:0] SEC_LAST = 26'(CYC_S - 1);

   drc_cfg_type    cfg;
   drc_state_type  state;
   drc_state_type  next_state;
   logic [4:0]     interval;
   logic [15:0]    ramp_set;
   logic [15:0]    top_f;
   logic [15:0]    up_f;
   logic [3:0]     hist [4];
   logic [1:0]     view_ptr;
   logic [3:0]     used;
   logic [3:0]     next_used;
   logic [25:0]    sec_cnt;
   logic [4:0]     wait_s;
   logic           fire;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wr       = req & wb_we_in;
   wire rd       = req & ~wb_we_in;
   wire hit_ctrl = wb_adr_in == OFS_CTRL;
   wire hit_int  = wb_adr_in == OFS_INTERVAL;
   wire hit_ramp = wb_adr_in == OFS_RAMP;
   wire hit_cmd  = wb_adr_in == OFS_CMD;
   wire hit_stat = wb_adr_in == OFS_STATUS;
   wire hit_view = wb_adr_in == OFS_TRIPVIEW;
   wire hit_topf = wb_adr_in == OFS_TOPF;
   wire hit_upf  = wb_adr_in == OFS_UPPERF;
   wire [31:0] m_ctrl = drc_merge({15'h0, cfg}, wb_dat_in, wb_sel_in);
   wire [31:0] m_int  = drc_merge({27'h0, interval}, wb_dat_in, wb_sel_in);
   wire [31:0] m_ramp = drc_merge({16'h0, ramp_set}, wb_dat_in, wb_sel_in);
   wire [31:0] m_topf = drc_merge({16'h0, top_f}, wb_dat_in, wb_sel_in);
   wire [31:0] m_upf  = drc_merge({16'h0, up_f}, wb_dat_in, wb_sel_in);
   wire cmd_ok  = wr & hit_cmd & wb_sel_in[0];
   wire confirm = cmd_ok & wb_dat_in[CMD_CONFIRM];
   wire cmd_rst = cmd_ok & wb_dat_in[CMD_RESET];
   wire cmd_stop = cmd_ok & wb_dat_in[CMD_STOP];
   wire cmd_run = cmd_ok & wb_dat_in[CMD_RUN];
   wire restore = confirm & cfg.factory_restore_select;

   // Count above ten is saturated so the sequencer never sees it
   drc_cfg_type new_cfg;
   always_comb begin
      new_cfg = drc_cfg_type'(m_ctrl[CFG_W-1:0]);
      if (new_cfg.retry_count_setting > RETRY_MAX) begin
         new_cfg.retry_count_setting = RETRY_MAX;
      end
   end

   // Read mux
   wire [31:0] status_word = {22'h0, energy_save_out, coast_out,
      running_out, fan_on_out, used, state};
   wire [31:0] rd_word = hit_ctrl ? {15'h0, cfg} :
                         hit_int  ? {27'h0, interval} :
                         hit_ramp ? {16'h0, ramp_set} :
                         hit_stat ? status_word :
                         hit_view ? {28'h0, hist[view_ptr]} :
                         hit_topf ? {16'h0, top_f} :
                         hit_upf  ? {16'h0, up_f} : 32'h0;

   // -----------------------------------------------------------------
   // Wishbone slave: one wait state, ack for every address
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0;
      end else begin
         wb_ack_out <= req;
         wb_dat_out <= rd ? rd_word : 32'h0;
      end
   end

   // Settings; a confirmed restore wins over a same-cycle write
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg      <= drc_cfg_type'(CFG_RST);
         interval <= INTERVAL_RST;
         ramp_set <= RAMP_RST;
         top_f    <= TOPF_RST;
         up_f     <= UPPERF_RST;
      end else if (restore) begin
         cfg      <= drc_cfg_type'(CFG_RST);
         interval <= INTERVAL_RST;
         ramp_set <= RAMP_RST;
         top_f    <= TOPF_RST;
         up_f     <= UPPERF_RST;
      end else begin
         if (wr && hit_ctrl) cfg <= new_cfg;
         if (wr && hit_int)
            interval <= drc_clamp(m_int[4:0], INTERVAL_MIN,
                                  INTERVAL_MAX);
         if (wr && hit_ramp) ramp_set <= m_ramp[15:0];
         if (wr && hit_topf) top_f <= m_topf[15:0];
         if (wr && hit_upf) up_f <= m_upf[15:0];
      end
   end

   // -----------------------------------------------------------------
   // Trip history
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hist[0] <= TRIP_NONE;
      end else if (trip_in) begin
         hist[0] <= trip_cause_in;
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < 4; gi++) begin : g_hist
         always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               hist[gi] <= TRIP_NONE;
            end else if (trip_in) begin
               hist[gi] <= hist[gi-1];
            end
         end
      end
   endgenerate

   // Each read steps older; a write to the trip view rewinds to the newest entry
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         view_ptr <= 2'h0;
      end else if (wr && hit_view) begin
         view_ptr <= 2'h0;
      end else if (rd && hit_view) begin
         view_ptr <= view_ptr + 2'h1;
      end
   end

   // -----------------------------------------------------------------
   // Retry sequencer
   // -----------------------------------------------------------------
   wire qual = (trip_cause_in >= overcurrent_trip) &&
               (trip_cause_in <= drive_overload_trip);
   wire can_retry = qual && (used < cfg.retry_count_setting);
   wire sec_tick = (state == DRC_ST_WAIT) && (sec_cnt == SEC_LAST);

   always_comb begin
      next_state = state;
      next_used  = used;
      fire       = 1'b0;
      case (state)
         DRC_ST_RUN: begin
            if (trip_in) begin
               next_state = can_retry ? DRC_ST_WAIT : DRC_ST_ALARM;
            end else if (at_speed_in) begin
               next_used = 4'h0;
            end
         end
         DRC_ST_WAIT: begin
            if (cmd_rst || cmd_stop) begin
               next_state = DRC_ST_RUN;
               next_used  = 4'h0;
            end else if (sec_tick && wait_s == 5'h01) begin
               fire       = 1'b1;
               next_state = DRC_ST_RUN;
               next_used  = used + 4'h1;
            end
         end
         DRC_ST_ALARM: begin
            if (cmd_rst) begin
               next_state = DRC_ST_RUN;
               next_used  = 4'h0;
            end
         end
         default: begin
            next_state = DRC_ST_ALARM;
         end
      endcase
   end

   // Second counter only runs while waiting, so each wait is whole
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state   <= DRC_ST_RUN;
         used    <= 4'h0;
         sec_cnt <= 26'h0;
         wait_s  <= 5'h0;
      end else begin
         state   <= next_state;
         used    <= next_used;
         sec_cnt <= (state != DRC_ST_WAIT || sec_tick) ? 26'h0
                    : sec_cnt + 26'h1;
         if (state != DRC_ST_WAIT) wait_s <= interval;
         else if (sec_tick) wait_s <= wait_s - 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // Start, pickup and stop
   // -----------------------------------------------------------------
   wire man_start = (cmd_run | power_loss_restart_in) & ~trip_in &
                    (state == DRC_ST_RUN);
   wire start_ev  = fire | man_start;
   wire pick_en   = (cfg.coasting_pickup_select == 2'h2) ||
                    (cfg.coasting_pickup_select == 2'h1 &&
                     power_loss_restart_in &&
                     cfg.power_loss_restart_select[1]);
   wire pick_fit  = (coast_freq_in <= PICKUP_MAX) &&
                    (coast_freq_in <= top_f) &&
                    (coast_freq_in <= up_f);

   // Trip drops the output; stop method only follows a stop command
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         start_out      <= 1'b0;
         start_freq_out <= 16'h0;
         pickup_out     <= 1'b0;
         auto_start_out <= 1'b0;
         running_out    <= 1'b0;
         coast_out      <= 1'b0;
         ramp_stop_out  <= 1'b0;
      end else begin
         start_out      <= start_ev;
         auto_start_out <= fire;
         pickup_out     <= start_ev & pick_en & pick_fit;
         ramp_stop_out  <= 1'b0;
         if (start_ev) begin
            start_freq_out <= (pick_en && pick_fit) ? coast_freq_in
                              : 16'h0;
            running_out    <= 1'b1;
            coast_out      <= 1'b0;
         end else if (trip_in) begin
            running_out <= 1'b0;
         end else if (cmd_stop && running_out) begin
            running_out   <= 1'b0;
            coast_out     <= cfg.halt_method_select;
            ramp_stop_out <= ~cfg.halt_method_select;
         end
      end
   end

   // -----------------------------------------------------------------
   // Ramp, fan, energy saving
   // -----------------------------------------------------------------
   wire ramp_free = (cfg.ramp_shape_select == 2'h0) || at_speed_in ||
                    stopped_in;
   wire ramp_xtr  = (ramp_time_out < RAMP_LIN_MIN) ||
                    (ramp_time_out > RAMP_LIN_MAX);
   wire s_curve   = (cfg.ramp_shape_select == 2'h1) ||
                    (cfg.ramp_shape_select == 2'h2);
   wire esave_ok  = cfg.power_saving_select && running_out &&
                    at_speed_in && light_load_in &&
                    (cfg.low_speed_boost_setting != 3'h0) &&
                    !accel_in && !decel_in && !torque_limit_in;

   // Pending ramp time lands at once on a linear ramp, else only at constant speed or standstill
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ramp_time_out   <= RAMP_RST;
         ramp_shape_out  <= 2'h0;
         fan_on_out      <= 1'b1;
         energy_save_out <= 1'b0;
         alarm_out       <= 1'b0;
      end else begin
         if (ramp_free) ramp_time_out <= ramp_set;
         ramp_shape_out  <= (s_curve && ramp_xtr) ? 2'h0
                            : cfg.ramp_shape_select;
         fan_on_out      <= ~cfg.fan_thermal_control_select |
                            heatsink_hot_in;
         energy_save_out <= esave_ok;
         alarm_out       <= next_state == DRC_ST_ALARM;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_hist_newest: assert property (trip_in |=>
      hist[0] == $past(trip_cause_in)) else $error("newest trip lost");
   a_hist_shift: assert property (trip_in |=>
      hist[3] == $past(hist[2]) && hist[1] == $past(hist[0]))
      else $error("history not shifted");
   a_restore_done: assert property (restore |=>
      !cfg.factory_restore_select && interval == INTERVAL_RST)
      else $error("restore incomplete");
   a_count_range: assert property (cfg.retry_count_setting <= RETRY_MAX)
      else $error("retry count above ten");
   a_nonqual_alarm: assert property (state == DRC_ST_RUN && trip_in
      && !qual |=> alarm_out) else $error("non-retry trip no alarm");
   a_exhaust_alarm: assert property (state == DRC_ST_RUN && trip_in
      && used >= cfg.retry_count_setting |=> state == DRC_ST_ALARM)
      else $error("retries exceeded without alarm");
   a_fire_count: assert property (fire |=>
      auto_start_out && used == $past(used) + 4'h1 && running_out)
      else $error("auto start not issued or counted");
   a_wait_reload: assert property ($rose(state == DRC_ST_WAIT) |->
      wait_s == interval && sec_cnt == 26'h0)
      else $error("retry wait not restarted");
   a_abandon: assert property (state == DRC_ST_WAIT &&
      (cmd_rst || cmd_stop) |=> state == DRC_ST_RUN && used == 4'h0 &&
      !auto_start_out) else $error("pending retry not abandoned");
   a_fan_always: assert property (!cfg.fan_thermal_control_select |=>
      fan_on_out) else $error("fan stopped");
   a_save_cancel: assert property (accel_in || decel_in ||
      torque_limit_in |=> !energy_save_out) else $error("saving on");
   a_coast_stop: assert property (cmd_stop && running_out && !start_ev
      && !trip_in && cfg.halt_method_select |=> coast_out &&
      !ramp_stop_out) else $error("coast stop not taken");
   a_pickup_cap: assert property (pickup_out |->
      start_freq_out <= PICKUP_MAX && start_freq_out <= up_f)
      else $error("pickup above limit");
endmodule
`default_nettype wire

// ===== verification/drc_stage.sv
/*
 Power stage model: spins up on a start, ramps, stops on a halt, and
 trips on request or again on a start while its fault persists.
 Assumes it shares one clock and reset with the supervisory block.
*/
`timescale 1ns/1ps
`default_nettype none
module drc_stage #(
   parameter int ACC = 12
) (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       start_in,
   input  wire logic       halt_in,
   input  wire logic       f_req_in,
   input  wire logic       f_hold_in,
   input  wire logic [3:0] f_cause_in,
   output logic            trip_out,
   output logic      [3:0] cause_out,
   output logic            accel_out,
   output logic            at_speed_out,
   output logic            stopped_out
);
   logic       spin;
   logic [4:0] left;
   // A start into a lasting fault trips at once, as real hardware would
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {spin, left, trip_out, cause_out} <= '0;
      end else begin
         trip_out <= f_req_in | (start_in & f_hold_in);
         if (f_req_in) cause_out <= f_cause_in;
         if (start_in & ~f_hold_in) begin
            spin <= 1'b1;
            left <= 5'(ACC);
         end else if (halt_in | trip_out) spin <= 1'b0;
         else if (left != 5'h00) left <= left - 5'h01;
      end
   end
   // Stage levels seen by the block
   assign accel_out    = spin & (left != 5'h00);
   assign at_speed_out = spin & (left == 5'h00);
   assign stopped_out  = ~spin;
endmodule
`default_nettype wire

// ===== verification/drc_top_tb.sv
/*
 Self-checking bench for drc_top: Wishbone tasks, random and corner
 stimulus. Assumes drc_stage as far side and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
 $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module drc_top_tb;
   import drc_pkg::*;
   localparam int CS = 20; // Short second keeps retry waits small
   logic        clk_in, rstn_in, cyc, stb, we, ack, trip, f_req, f_hold;
   logic        plr, hot, dec, lite, tlim, acc, spd, stp, st, pk, au;
   logic        run, cst, rs, alm, fan, es;
   logic [1:0]  shp;
   logic [3:0]  cause, f_cause, sel;
   logic [7:0]  adr;
   logic [15:0] cf, sf, rt, last_sf, ex;
   logic [31:0] wd, dout, rd;
   int          mismatches, compares, cyc_n, n_au, n_rs, n_pk, t_tr, t_au;
   int          n0;
   logic [3:0]  hist[5];
   logic [4:0]  ivs[3] = '{5'h19, 5'h0B, 5'h01};
   logic [1:0]  fv[3] = '{2'b10, 2'b11, 2'b00};
   logic [18:0] ev[4] = '{19'h11081, 19'h11084, 19'h11082, 19'h01080};
   logic [33:0] pkt[7] = '{34'h04400001, 34'h04400A29, 34'h024004B2,
      34'h424004B3, 34'h044012C1, 34'h044012C5, 34'h004004B0};
   drc_top #(.CYC_S(CS)) drc_top_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dout), .wb_ack_out(ack),
      .trip_in(trip), .trip_cause_in(cause), .power_loss_restart_in(plr),
      .coast_freq_in(cf), .heatsink_hot_in(hot), .accel_in(acc),
      .decel_in(dec), .at_speed_in(spd), .stopped_in(stp),
      .light_load_in(lite), .torque_limit_in(tlim), .start_out(st),
      .start_freq_out(sf), .pickup_out(pk), .auto_start_out(au),
      .running_out(run), .coast_out(cst), .ramp_stop_out(rs),
      .alarm_out(alm), .fan_on_out(fan), .energy_save_out(es),
      .ramp_shape_out(shp), .ramp_time_out(rt));
   drc_stage #(.ACC(12)) drc_stage_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .start_in(st), .halt_in(rs | cst), .f_req_in(f_req),
      .f_hold_in(f_hold), .f_cause_in(f_cause), .trip_out(trip),
      .cause_out(cause), .accel_out(acc), .at_speed_out(spd),
      .stopped_out(stp));
   // 40 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   function automatic logic [4:0] clampi(input logic [4:0] v);
      return (v < INTERVAL_MIN) ? INTERVAL_MIN :
             (v > INTERVAL_MAX) ? INTERVAL_MAX : v;
   endfunction
   function automatic logic [15:0] pickf(input logic [15:0] f, lim);
      return (f > PICKUP_MAX || f > lim) ? 16'h0000 : f;
   endfunction
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      {cyc, stb, we, sel, adr, wd} <= {2'b11, w, 4'hF, a, d};
      do tk(1); while (ack !== 1'b1);
      rd = dout;
      {cyc, stb} <= 2'b00;
      tk(2);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic fault(input logic [3:0] c);
      f_req   <= 1'b1;
      f_cause <= c;
      tk(1);
      f_req   <= 1'b0;
      tk(4);
   endtask
   // Pulse counters and hang guard; pulses are seen at every rising edge
   always @(posedge clk_in) begin
      cyc_n++;
      if (trip === 1'b1) t_tr = cyc_n;
      if (au === 1'b1) begin
         n_au++;
         t_au = cyc_n;
      end
      if (rs === 1'b1) n_rs++;
      if (pk === 1'b1) n_pk++;
      if (st === 1'b1) last_sf = sf;
      if (cyc_n > 6000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(89));
      {cyc, stb, we, f_req, f_hold, plr, hot, dec, lite, tlim} = '0;
      {adr, wd, f_cause, cf, sel} = '0;
      rstn_in = 1'b0;
      tk(4);
      rstn_in <= 1'b1;
      tk(1);
      `CHK({fan, rt}, 17'h1003C)
      rdc(OFS_INTERVAL, 32'h2);
      rdc(8'h40, 32'h0);
      wr(OFS_CTRL, 32'h1F);
      rdc(OFS_CTRL, 32'h1A);
      foreach (ivs[i]) begin
         wr(OFS_INTERVAL, {27'h0, ivs[i]});
         rdc(OFS_INTERVAL, {27'h0, clampi(ivs[i])});
      end
      wr(OFS_CTRL, 32'h10);
      foreach (hist[i]) begin
         hist[i] = 4'($urandom_range(15, 1));
         fault(hist[i]);
         `CHK(alm, 1'b1)
      end
      wr(OFS_TRIPVIEW, 32'h0);
      for (int i = 4; i > 0; i--) rdc(OFS_TRIPVIEW, {28'h0, hist[i]});
      wr(OFS_CMD, 32'h2);
      wr(OFS_CTRL, 32'h13);
      // Seven retry causes each recover; a last foreign cause alarms
      for (int c = 1; c < 9; c++) begin
         n0 = n_au;
         fault((c == 8) ? 4'($urandom_range(15, 8)) : 4'(c));
         tk(80);
         bus(1'b0, OFS_STATUS, 32'h0);
         if (c < 8) begin
            `CHK(n_au - n0, 1)
            `CHK(t_au - t_tr, 2 * CS + 1)
            `CHK({run, alm, rd[5:2]}, 6'h20)
         end else `CHK({alm, n_au}, {1'b1, n0})
      end
      wr(OFS_CMD, 32'h2);
      wr(OFS_CTRL, 32'h12);
      f_hold <= 1'b1;
      n0 = n_au;
      fault(4'h2);
      tk(150);
      `CHK({alm, n_au - n0}, {1'b1, 32'h2})
      f_hold <= 1'b0;
      wr(OFS_CMD, 32'h2);
      `CHK(alm, 1'b0)
      fault(4'h1);
      wr(OFS_CMD, 32'h4);
      tk(60);
      `CHK(n_au - n0, 2)
      foreach (fv[i]) begin
         wr(OFS_CTRL, {27'h0, fv[i][1], 4'h0});
         hot <= fv[i][0];
         tk(3);
         `CHK(fan, ~fv[i][1] | fv[i][0])
      end
      for (int s = 0; s < 4; s++) begin
         wr(OFS_CTRL, 32'h10 | (s << 5));
         `CHK(shp, 2'(s))
      end
      wr(OFS_CTRL, 32'h30);
      wr(OFS_RAMP, 32'h1);
      `CHK(shp, 2'h0)
      wr(OFS_RAMP, 32'h3C);
      wr(OFS_CTRL, 32'h70);
      wr(OFS_CMD, 32'h8);
      wr(OFS_RAMP, 32'h50);
      `CHK(rt, 16'h003C)
      tk(20);
      `CHK(rt, 16'h0050)
      lite <= 1'b1;
      foreach (ev[i]) begin
         wr(OFS_CTRL, {16'h0, ev[i][18:3]});
         {dec, tlim} <= ev[i][2:1];
         tk(3);
         `CHK(es, ev[i][0])
      end
      {dec, tlim} <= 2'b00;
      n0 = n_rs;
      wr(OFS_CMD, 32'h4);
      `CHK({run, cst, n_rs - n0}, {2'b00, 32'h1})
      wr(OFS_CMD, 32'h8);
      wr(OFS_CTRL, 32'h410);
      wr(OFS_CMD, 32'h4);
      `CHK({run, cst, n_rs - n0}, {2'b01, 32'h1})
      pkt[0][17:2] = 16'($urandom_range(599, 1));
      foreach (pkt[i]) begin
         if (i == 3) wr(OFS_TOPF, 32'h7FF);
         if (i == 3) wr(OFS_UPPERF, 32'h7FF);
         wr(OFS_CTRL, {16'h0, pkt[i][33:18]});
         cf <= pkt[i][17:2];
         last_sf = 16'hFFFF;
         n0 = n_pk;
         if (pkt[i][1]) begin
            plr <= 1'b1;
            tk(1);
            plr <= 1'b0;
         end else wr(OFS_CMD, 32'h8);
         tk(3);
         ex = pkt[i][0] ? pickf(cf, (i < 3) ? TOPF_RST : 16'h07FF) : 16'h0;
         `CHK({last_sf, n_pk - n0}, {ex, int'(ex != 16'h0)})
         wr(OFS_CMD, 32'h4);
      end
      wr(OFS_CTRL, 32'h1001F);
      wr(OFS_CMD, 32'h1);
      rdc(OFS_CTRL, 32'h10);
      rdc(OFS_TOPF, {16'h0, TOPF_RST});
      print_verdict();
   end
endmodule
`default_nettype wire
